//--- hdl/scpd_ctrl.sv
// Operation
// - Halt command stops all, then clears itself
// - Normal start launches masked channels, clears after
// - Data register flags channels that failed start
// - Unit numbers readable only before first trigger
// - Data register flags channels whose transfer failed
// - Trigger exchanges data on masked channels
// - Trigger completes within bounded time limit
// - Status and payload words refilled after transfer
// - Card modes: outputs only, or outputs plus voltage
// - Fixed bit layout of card payload words
// - Setup start gives raw parameter pass-through
// - Channels idle after reset or halt
// - Word read: command, address in status word
// - Read sizes use consecutive command codes
// - Write sizes use consecutive command codes
// - Data register zero after good parameter access
// - Payload word two holds table pointer
// - Elements packed low to high, word zero first
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module scpd_ctrl
	import scpd_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = XFER_LIMIT_CYC
)
(
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic [7:0]                 busAddr,
	input  wire logic [31:0]                busWrData,
	input  wire logic                       busWr,
	input  wire logic                       busRd,
	output logic      [31:0]                busRdData,
	output logic                            linkReqValid,
	output logic      [CHAN_W-1:0]          linkReqChan,
	output logic      [1:0]                 linkReqOp,
	output logic                            linkReqSetup,
	output logic      [31:0]                linkReqCs,
	output logic      [PAYLOAD_W-1:0]       linkReqData,
	output logic                            linkHalt,
	input  wire logic                       linkRespValid,
	input  wire logic [CHAN_W-1:0]          linkRespChan,
	input  wire logic                       linkRespFail,
	input  wire logic [31:0]                linkRespStatus,
	input  wire logic [PAYLOAD_W-1:0]       linkRespData,
	input  wire logic [UNIT_W-1:0]          linkRespUnit,
	output logic      [NUM_CHAN-1:0]        chanRunning,
	output logic                            busy
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Lowest set bit of a channel mask, with a found flag on top
	function automatic logic [CHAN_W:0] firstSet(input logic [NUM_CHAN-1:0] mask);
		logic [CHAN_W:0] res;
		res = '0;
		for (int i = NUM_CHAN - 1; i >= 0; i--)
		begin
			if (mask[i])
			begin
				res = {1'b1, CHAN_W'(i)};
			end
		end
		return res;
	endfunction

	// Maps a command code to an engine operation; top bit marks a valid code
	function automatic logic [2:0] decodeCmd(input logic [7:0] code);
		logic [2:0] res;
		res = '0;
		unique case (code)
			CMD_NORMAL: res = {1'b1, OP_NORMAL_START};
			CMD_SETUP:  res = {1'b1, OP_SETUP_START};
			CMD_XFER:   res = {1'b1, OP_XFER};
			default:    res = '0;
		endcase
		return res;
	endfunction

	// Deadline compare point; the margin covers the done and clear cycles,
	// so the command word reads clear by the limit and not just after it
	localparam logic [TMR_W-1:0] TIMER_LAST = TMR_W'(TIMEOUT_CYCLES - FINISH_MARGIN);

	// Whole block state, current value and next value
	scpd_regs_t r;
	scpd_regs_t n;

	// Decode helpers, all combinational from the bus and the state
	logic [7:0]        chanOff;
	logic              chanHit;
	logic [CHAN_W-1:0] busChan;
	logic [1:0]        busWord;
	logic [7:0]        wrCode;
	logic [2:0]        wrKind;
	logic [CHAN_W:0]   nextChan;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// Channel window is a flat block of four words per channel
	assign chanOff  = busAddr - ADDR_CHAN_BASE;
	assign chanHit  = (busAddr >= ADDR_CHAN_BASE) && (busAddr < ADDR_CHAN_END);
	assign busChan  = chanOff[CHAN_SEL_LSB +: CHAN_W];
	assign busWord  = chanOff[WORD_SEL_LSB +: 2];
	assign wrCode   = busWrData[CMD_CODE_LSB +: 8];
	assign wrKind   = decodeCmd(wrCode);
	assign nextChan = firstSet(r.pending);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// All decisions in one place so priorities stay visible
	always_comb
	begin
		n          = r;
		n.reqValid = 1'b0;
		n.halt     = 1'b0;
		n.rdData   = '0;

		// Read answer, one cycle after the strobe; unmapped reads give zero
		if (busRd)
		begin
			if (busAddr == ADDR_CMD)
			begin
				n.rdData = r.cmd;
			end
			else if (busAddr == ADDR_DATA)
			begin
				n.rdData = {{(32-NUM_CHAN){1'b0}}, r.data};
			end
			else if (busAddr == ADDR_UNIT_LO)
			begin
				n.rdData = r.unitOpen ? {r.unit[3], r.unit[2], r.unit[1], r.unit[0]} : '0;
			end
			else if (busAddr == ADDR_UNIT_HI)
			begin
				n.rdData = r.unitOpen ? {r.unit[7], r.unit[6], r.unit[5], r.unit[4]} : '0;
			end
			else if (chanHit)
			begin
				unique case (busWord)
					WORD_STATUS: n.rdData = r.cs[busChan];
					WORD_DATA0:  n.rdData = r.iface[busChan][0];
					WORD_DATA1:  n.rdData = r.iface[busChan][1];
					WORD_DATA2:  n.rdData = r.iface[busChan][2];
				endcase
			end
		end

		// Host loads status and payload words; an engine answer later wins
		if (busWr && chanHit)
		begin
			unique case (busWord)
				WORD_STATUS: n.cs[busChan]       = busWrData;
				WORD_DATA0:  n.iface[busChan][0] = busWrData;
				WORD_DATA1:  n.iface[busChan][1] = busWrData;
				WORD_DATA2:  n.iface[busChan][2] = busWrData;
			endcase
		end

		// Sequencer
		unique case (r.state)
			ST_IDLE:
			begin
				// Channels stay quiet here until a start or trigger is taken
				n.pending = '0;
			end

			ST_SCAN:
			begin
				// Lowest pending channel first, one exchange at a time
				if (!nextChan[CHAN_W])
				begin
					n.state = ST_DONE;
				end
				else if (r.op == OP_XFER && !r.running[nextChan[CHAN_W-1:0]])
				begin
					// A channel never started cannot exchange
					n.fails[nextChan[CHAN_W-1:0]]   = 1'b1;
					n.pending[nextChan[CHAN_W-1:0]] = 1'b0;
				end
				else
				begin
					// Outgoing words pass unchanged, card layout is software's
					n.reqValid = 1'b1;
					n.chan     = nextChan[CHAN_W-1:0];
					n.reqSetup = r.setupMode[nextChan[CHAN_W-1:0]];
					n.reqCs    = r.cs[nextChan[CHAN_W-1:0]];
					n.reqData  = r.iface[nextChan[CHAN_W-1:0]];
					n.state    = ST_WAIT;
				end
			end

			ST_WAIT:
			begin
				// Answers tagged with another channel are stale and dropped
				if (linkRespValid && linkRespChan == r.chan)
				begin
					n.pending[r.chan] = 1'b0;
					n.cs[r.chan]      = linkRespStatus;
					n.iface[r.chan]   = linkRespData;
					if (linkRespFail)
					begin
						n.fails[r.chan] = 1'b1;
					end
					if (r.op != OP_XFER)
					begin
						n.running[r.chan]   = !linkRespFail;
						n.setupMode[r.chan] = (r.op == OP_SETUP_START);
						n.unit[r.chan]      = linkRespUnit;
					end
					n.state = ST_SCAN;
				end
			end

			ST_HALT:
			begin
				// Halt takes one cycle, then the command word reads clear
				n.running   = '0;
				n.setupMode = '0;
				n.pending   = '0;
				n.unitOpen  = 1'b0;
				n.halt      = 1'b1;
				n.cmd       = '0;
				n.state     = ST_IDLE;
			end

			ST_DONE:
			begin
				// Fault bits become visible in the cycle the word clears,
				// so a poller never sees a clear word with stale faults
				n.cmd   = '0;
				n.data  = r.fails;
				n.state = ST_IDLE;
				if (r.op != OP_XFER)
				begin
					n.unitOpen = 1'b1;
				end
			end

			default:
			begin
				n.state = ST_IDLE;
			end
		endcase

		// Transfer deadline: leftover channels count as failed so the
		// command word clears in time even if the engine stalls
		if (r.op == OP_XFER && (r.state == ST_SCAN || r.state == ST_WAIT))
		begin
			n.timer = r.timer + TMR_W'(1);
			if (r.timer >= TIMER_LAST)
			begin
				n.fails   = n.fails | n.pending;
				n.pending = '0;
				n.state   = ST_DONE;
			end
		end

		// Command write: halt always taken, ignore bit keeps the old word even over a sequencer clear,
		// anything else only while the word is clear
		// Placed last so a halt beats any sequencer decision in this cycle
		if (busWr && busAddr == ADDR_CMD)
		begin
			if (wrCode == CMD_HALT)
			begin
				n.cmd     = busWrData;
				n.state   = ST_HALT;
				n.pending = '0;
			end
			else if (busWrData[CMD_IGNORE_BIT])
			begin
				n.cmd = r.cmd;
			end
			else if (r.cmd == '0 && r.state == ST_IDLE && wrKind[2])
			begin
				n.cmd     = busWrData;
				n.op      = wrKind[1:0];
				n.pending = busWrData[NUM_CHAN-1:0];
				n.fails   = '0;
				n.timer   = '0;
				n.state   = ST_SCAN;
				if (wrKind[1:0] == OP_XFER)
				begin
					n.unitOpen = 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Clock enable low freezes everything, including the deadline timer
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			r       <= '0;
			r.state <= ST_IDLE;
		end
		else if (ce)
		begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// All straight from the state register
	assign busRdData    = r.rdData;
	assign linkReqValid = r.reqValid;
	assign linkReqChan  = r.chan;
	assign linkReqOp    = r.op;
	assign linkReqSetup = r.reqSetup;
	assign linkReqCs    = r.reqCs;
	assign linkReqData  = r.reqData;
	assign linkHalt     = r.halt;
	assign chanRunning  = r.running;
	// Busy mirrors a nonzero command word, the host's only completion flag
	assign busy         = (r.cmd != '0);

endmodule

`default_nettype wire

//--- hdl/scpd_pkg.sv
package scpd_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int          NUM_CHAN    = 8;
	localparam int          CHAN_W      = 3;
	localparam int          IFACE_WORDS = 3;
	localparam int          PAYLOAD_W   = 96;
	localparam int          UNIT_W      = 8;
	localparam int          TMR_W       = 16;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CMD       = 8'h00;
	localparam logic [7:0]  ADDR_DATA      = 8'h04;
	localparam logic [7:0]  ADDR_UNIT_LO   = 8'h08;
	localparam logic [7:0]  ADDR_UNIT_HI   = 8'h0c;
	localparam logic [7:0]  ADDR_CHAN_BASE = 8'h40;
	localparam logic [7:0]  ADDR_CHAN_END  = 8'hc0;
	localparam int          CHAN_SEL_LSB   = 4;
	localparam int          WORD_SEL_LSB   = 2;
	localparam logic [1:0]  WORD_STATUS    = 2'h0;
	localparam logic [1:0]  WORD_DATA0     = 2'h1;
	localparam logic [1:0]  WORD_DATA1     = 2'h2;
	localparam logic [1:0]  WORD_DATA2     = 2'h3;

	// ----------------------------------------------------------------
	// Command word layout
	// ----------------------------------------------------------------
	localparam int          CMD_CODE_LSB   = 8;
	localparam int          CMD_IGNORE_BIT = 14;
	localparam logic [7:0]  CMD_HALT       = 8'h08;
	localparam logic [7:0]  CMD_NORMAL     = 8'h09;
	localparam logic [7:0]  CMD_SETUP      = 8'h0f;
	localparam logic [7:0]  CMD_XFER       = 8'h10;

	// ----------------------------------------------------------------
	// Operations presented to the serial engine
	// ----------------------------------------------------------------
	localparam logic [1:0]  OP_NORMAL_START = 2'h0;
	localparam logic [1:0]  OP_SETUP_START  = 2'h1;
	localparam logic [1:0]  OP_XFER         = 2'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_MHZ          = 200;
	localparam int          XFER_LIMIT_NS    = 100000;
	localparam int          XFER_LIMIT_CYC   = XFER_LIMIT_NS * CLK_MHZ / 1000;
	localparam int          FINISH_MARGIN    = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'b00001,
		ST_SCAN = 5'b00010,
		ST_WAIT = 5'b00100,
		ST_HALT = 5'b01000,
		ST_DONE = 5'b10000
	} scpd_state_t;

	typedef struct packed
	{
		scpd_state_t                                 state;
		logic [31:0]                                 cmd;
		logic [NUM_CHAN-1:0]                         data;
		logic [NUM_CHAN-1:0]                         running;
		logic [NUM_CHAN-1:0]                         setupMode;
		logic                                        unitOpen;
		logic [NUM_CHAN-1:0][UNIT_W-1:0]             unit;
		logic [NUM_CHAN-1:0][31:0]                   cs;
		logic [NUM_CHAN-1:0][IFACE_WORDS-1:0][31:0]  iface;
		logic [NUM_CHAN-1:0]                         pending;
		logic [NUM_CHAN-1:0]                         fails;
		logic [1:0]                                  op;
		logic [CHAN_W-1:0]                           chan;
		logic [TMR_W-1:0]                            timer;
		logic                                        reqValid;
		logic                                        reqSetup;
		logic [31:0]                                 reqCs;
		logic [PAYLOAD_W-1:0]                        reqData;
		logic                                        halt;
		logic [31:0]                                 rdData;
	} scpd_regs_t;

endpackage

//--- dv/scpd_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module scpd_link_model
	import scpd_pkg::*;
#(
	parameter logic [PAYLOAD_W-1:0] PAT     = '0,
	parameter logic [15:0]          FIELD_V = 16'h0000
)
(
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic [NUM_CHAN-1:0]  failMask,
	input  wire logic [7:0]           respDelay,
	input  wire logic                 linkReqValid,
	input  wire logic [CHAN_W-1:0]    linkReqChan,
	input  wire logic [1:0]           linkReqOp,
	input  wire logic [31:0]          linkReqCs,
	input  wire logic [PAYLOAD_W-1:0] linkReqData,
	output logic                      linkRespValid,
	output logic      [CHAN_W-1:0]    linkRespChan,
	output logic                      linkRespFail,
	output logic      [31:0]          linkRespStatus,
	output logic      [PAYLOAD_W-1:0] linkRespData,
	output logic      [UNIT_W-1:0]    linkRespUnit
);
	logic                 waiting;
	logic                 answer;
	logic [7:0]           waitCnt;
	logic [CHAN_W-1:0]    chan;
	logic [PAYLOAD_W-1:0] ansData;
	logic [31:0]          lastCs;
	logic [PAYLOAD_W-1:0] lastData;

	// Idle lines show the inverse, so a stale answer never looks valid
	assign linkRespValid  = answer;
	assign linkRespChan   = answer ? chan : ~chan;
	assign linkRespFail   = answer ? failMask[chan] : ~failMask[chan];
	assign linkRespStatus = answer ? 32'h0403_0201 : 32'hfbfc_fdfe;
	assign linkRespData   = answer ? ansData : ~ansData;
	assign linkRespUnit   = answer ? 8'h20 + 8'(chan) : 8'hdf - 8'(chan);

	// One exchange at a time; delay 0xff is a card that never answers
	always_ff @(posedge ref_clk)
	begin
		answer <= 1'b0;
		if (rst)
			waiting <= 1'b0;
		else if (linkReqValid)
		begin
			waiting  <= 1'b1;
			waitCnt  <= respDelay;
			chan     <= linkReqChan;
			lastCs   <= linkReqCs;
			lastData <= linkReqData;
			if (linkReqOp == OP_SETUP_START)
				ansData <= {32'h0000_0100, 64'h0};
			else if (linkReqOp == OP_XFER && linkReqCs[31:26] == 6'b010001)
				// Addresses with bit 2 set read as zero, so table walks and strings end
				ansData <= linkReqCs[2] ? '0
					: PAT & ((96'h1 << (8 << linkReqCs[25:24])) - 96'h1);
			else if (linkReqOp == OP_XFER && linkReqCs[31:26] == 6'b011001)
				ansData <= '0;
			else
				ansData <= {80'h0, FIELD_V};
		end
		else if (waiting && waitCnt == 8'h00)
		begin
			waiting <= 1'b0;
			answer  <= 1'b1;
		end
		else if (waiting && waitCnt != 8'hff)
			waitCnt <= waitCnt - 8'h01;
	end
endmodule

`default_nettype wire

//--- dv/scpd_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module scpd_ctrl_asserts
	import scpd_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = XFER_LIMIT_CYC
)
(
	input wire logic                ref_clk,
	input wire logic                rst,
	input wire logic [7:0]          busAddr,
	input wire logic [31:0]         busWrData,
	input wire logic                busWr,
	input wire logic                busRd,
	input wire logic [31:0]         busRdData,
	input wire logic                linkReqValid,
	input wire logic [CHAN_W-1:0]   linkReqChan,
	input wire logic [1:0]          linkReqOp,
	input wire logic                linkHalt,
	input wire logic                linkRespValid,
	input wire logic [CHAN_W-1:0]   linkRespChan,
	input wire logic [NUM_CHAN-1:0] chanRunning,
	input wire logic                busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	logic       reqOpen;
	logic [7:0] lastCode;
	int         xferAge;

	// Open request and age of a running transfer; starts have no bound
	always_ff @(posedge ref_clk)
	begin
		if (rst || linkHalt || !busy || (linkRespValid && linkRespChan == linkReqChan))
			reqOpen <= 1'b0;
		else if (linkReqValid)
			reqOpen <= 1'b1;
		if (rst)
			lastCode <= 8'h00;
		else if (busWr && busAddr == ADDR_CMD && !busy)
			lastCode <= busWrData[15:8];
		xferAge <= (busy && lastCode == CMD_XFER) ? xferAge + 1 : 0;
	end

	sequence cmdTaken(logic [7:0] code);
		busWr && !busy && busAddr == ADDR_CMD && busWrData[15:8] == code && busWrData[7:0] != 8'h00;
	endsequence
	sequence haltSteps;
		busy ##1 (linkHalt && !busy && chanRunning == '0);
	endsequence

	halt_clear_a: assert property (busWr && busAddr == ADDR_CMD && busWrData[15:8] == CMD_HALT |=> haltSteps)
		else $error("halt did not stop and clear");
	cmd_accept_a: assert property (cmdTaken(CMD_NORMAL) or cmdTaken(CMD_SETUP) |=> busy[*2])
		else $error("start command not taken");
	ignore_bit_a: assert property (busWr && !busy && busAddr == ADDR_CMD && busWrData[CMD_IGNORE_BIT] |=> !busy ##1 (!busy || $past(busWr)))
		else $error("ignored command acted");
	xfer_bound_a: assert property (xferAge <= TIMEOUT_CYCLES + 6)
		else $error("transfer overran its limit");
	xfer_running_a: assert property (linkReqValid && linkReqOp == OP_XFER |-> chanRunning[linkReqChan])
		else $error("transfer sent to idle channel");
	one_outstanding_a: assert property (linkReqValid |-> !reqOpen)
		else $error("second request while one open");
	req_busy_a: assert property (linkReqValid |-> busy)
		else $error("request without a command");
	rd_window_a: assert property (busRdData != '0 |-> $past(busRd))
		else $error("read data outside its cycle");
endmodule

bind scpd_ctrl scpd_ctrl_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_check
(
	.ref_clk, .rst, .busAddr, .busWrData, .busWr, .busRd, .busRdData, .linkReqValid,
	.linkReqChan, .linkReqOp, .linkHalt, .linkRespValid, .linkRespChan, .chanRunning, .busy
);

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
	import scpd_pkg::*;
;
	localparam int          TO_CYC  = 50;
	localparam logic [95:0] PAT     = 96'h0123_4567_89ab_cdef_fedc_baa0;
	localparam logic [15:0] FIELD_V = 16'h0abc;

	logic                 ref_clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 busWr = 1'b0;
	logic                 busRd = 1'b0;
	logic [7:0]           busAddr = 8'h00;
	logic [31:0]          busWrData = 32'h0;
	logic [NUM_CHAN-1:0]  failMask = 8'h00;
	logic [7:0]           respDelay = 8'h03;
	logic [31:0]          busRdData, rdv, linkReqCs, linkRespStatus;
	logic                 linkReqValid, linkReqSetup, linkHalt, busy, linkRespValid, linkRespFail;
	logic [CHAN_W-1:0]    linkReqChan, linkRespChan;
	logic [1:0]           linkReqOp;
	logic [PAYLOAD_W-1:0] linkReqData, linkRespData;
	logic [UNIT_W-1:0]    linkRespUnit;
	logic [NUM_CHAN-1:0]  chanRunning;
	int                   failCount = 0;
	int                   checksDone = 0;

	scpd_ctrl #(.TIMEOUT_CYCLES(TO_CYC)) u_dut
	(
		.ref_clk, .rst, .ce(1'b1), .busAddr, .busWrData, .busWr, .busRd, .busRdData,
		.linkReqValid, .linkReqChan, .linkReqOp, .linkReqSetup, .linkReqCs, .linkReqData,
		.linkHalt, .linkRespValid, .linkRespChan, .linkRespFail, .linkRespStatus,
		.linkRespData, .linkRespUnit, .chanRunning, .busy
	);
	scpd_link_model #(.PAT(PAT), .FIELD_V(FIELD_V)) u_far
	(
		.ref_clk, .rst, .failMask, .respDelay, .linkReqValid, .linkReqChan, .linkReqOp,
		.linkReqCs, .linkReqData, .linkRespValid, .linkRespChan, .linkRespFail,
		.linkRespStatus, .linkRespData, .linkRespUnit
	);

	always #2.5 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------
	// Bus cycles and checking
	// ----------------------------------------------------------------
	function automatic logic [7:0] chAddr(input int ch, input logic [1:0] w);
		return ADDR_CHAN_BASE + 8'(ch * 16) + {4'h0, w, 2'b00};
	endfunction
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		checksDone++;
		if (ok !== 1'b1)
		begin
			failCount++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// Strobes are one cycle; the settle delay keeps sampling off the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		busAddr <= a;
		busWrData <= d;
		busWr <= 1'b1;
		@(posedge ref_clk);
		busWr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge ref_clk);
		busRd <= 1'b0;
		#1;
		rdv = busRdData;
	endtask
	task automatic cmd(input logic [31:0] d, input int n);
		int i;
		wr(ADDR_CMD, d);
		for (i = 0; i < n && busy !== 1'b0; i++)
		begin
			@(posedge ref_clk);
			#1;
		end
		check(busy === 1'b0, "command never cleared");
		if (busy !== 1'b0)
			complete_run();
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_idle();
		rd(chAddr(0, WORD_STATUS));
		check(rdv === 32'h0 && chanRunning === 8'h00, "not idle after reset");
		rd(8'hfc);
		check(rdv === 32'h0, "unmapped read");
		wr(ADDR_CMD, 32'h0000_5001);
		check(busy === 1'b0, "ignored command acted");
		cmd(32'h0000_0800, 8);
	endtask
	task automatic t_normal_start();
		failMask <= 8'h02;
		cmd(32'h0000_0903, 200);
		rd(ADDR_DATA);
		check(rdv === 32'h02 && chanRunning === 8'h01, "start fault bits");
		rd(ADDR_UNIT_LO);
		check(rdv[7:0] === 8'h20, "unit number");
	endtask
	task automatic t_transfer();
		wr(chAddr(0, WORD_DATA0), 32'h89ab_cdef);
		wr(chAddr(0, WORD_DATA1), 32'h0000_4567);
		cmd(32'h0000_1003, TO_CYC + 10);
		check(linkReqSetup === 1'b0, "normal channel flagged setup");
		check(u_far.lastData[47:0] === 48'h4567_89ab_cdef, "outgoing payload");
		rd(ADDR_DATA);
		check(rdv === 32'h02, "transfer fault bits");
		rd(chAddr(0, WORD_STATUS));
		check(rdv === 32'h0403_0201, "status word");
		rd(chAddr(0, WORD_DATA0));
		check(rdv === {16'h0, FIELD_V}, "field voltage");
		rd(ADDR_UNIT_LO);
		check(rdv === 32'h0, "unit after trigger");
	endtask
	task automatic t_silent_card();
		respDelay <= 8'hff;
		cmd(32'h0000_1001, TO_CYC + 10);
		rd(ADDR_DATA);
		check(rdv === 32'h01, "silent channel not flagged");
		respDelay <= 8'h03;
	endtask
	task automatic t_setup_access();
		int k;
		logic [95:0] want;
		cmd(32'h0000_0800, 8);
		failMask <= 8'h00;
		cmd(32'h0000_0f01, 200);
		rd(chAddr(0, WORD_DATA2));
		check(rdv === 32'h100, "table pointer");
		for (k = 0; k < 4; k++)
		begin
			want = PAT & ((96'h1 << (8 << k)) - 96'h1);
			wr(chAddr(0, WORD_STATUS), {8'h44 + 8'(k), 8'h00, 16'h0010});
			cmd(32'h0000_1001, TO_CYC + 10);
			check(linkReqSetup === 1'b1, "setup channel not flagged");
			rd(ADDR_DATA);
			check(rdv === 32'h0, "read access error");
			rd(chAddr(0, WORD_DATA0));
			check(rdv === want[31:0], "read data low");
			rd(chAddr(0, WORD_DATA1));
			check(rdv === want[63:32], "read data high");
			wr(chAddr(0, WORD_DATA0), 32'h1234_5670 + 32'(k));
			wr(chAddr(0, WORD_STATUS), {8'h64 + 8'(k), 8'h00, 16'h0020});
			cmd(32'h0000_1001, TO_CYC + 10);
			check(u_far.lastCs[31:24] === 8'h64 + 8'(k), "write code");
			check(u_far.lastData[31:0] === 32'h1234_5670 + 32'(k), "write data");
		end
	endtask

	// One pass-through read on channel 0; the answer lands in rdv
	task automatic remote_rd(input logic [1:0] sz, input logic [15:0] a);
		wr(chAddr(0, WORD_STATUS), {8'h44 + 8'(sz), 8'h00, a});
		cmd(32'h0000_1001, TO_CYC + 10);
		rd(chAddr(0, WORD_DATA0));
	endtask
	// Host side discovery: walk the table, then parse the first record
	task automatic t_discovery();
		logic [15:0] ptr;
		logic [15:0] entry;
		int          cnt;
		int          i;
		ptr   = 16'h0100; // Pointer read back after setup start
		entry = 16'h0000;
		cnt   = 0;
		for (i = 0; i < 4; i++)
		begin
			remote_rd(2'h1, ptr);
			if (rdv[15:0] == 16'h0000)
				break;
			if (cnt == 0)
				entry = rdv[15:0];
			cnt++;
			ptr = ptr + 16'h0002;
		end
		check(cnt == 2 && entry === PAT[15:0], "table walk");
		remote_rd(2'h0, entry);
		check(rdv[7:0] === 8'ha0, "record type");
		if (rdv[7:0] == 8'ha0)
		begin
			for (i = 1; i < 4; i++)
			begin
				remote_rd(2'h0, entry + 16'(i));
			end
			remote_rd(2'h2, entry + 16'h0004);
			remote_rd(2'h2, entry + 16'h0008);
			remote_rd(2'h1, entry + 16'h000a);
			ptr = entry + 16'h000c;
			for (i = 0; i < 8; i++)
			begin
				remote_rd(2'h0, ptr);
				if (rdv[7:0] == 8'h00)
					break;
				ptr = ptr + 16'h0001;
			end
			check(u_far.lastCs[15:0] === entry + 16'h000c && i == 0, "unit string");
		end
	endtask

	// Main sequence, then a watchdog that cuts a hang short
	initial
	begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		t_reset_idle();
		t_normal_start();
		t_transfer();
		t_silent_card();
		t_setup_access();
		t_discovery();
		complete_run();
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		check(1'b0, "run did not finish");
		complete_run();
	end
endmodule

`default_nettype wire
